// ### verilog/dseq_pkg.sv
// Package: constants, register map and carriers for the discharge sequencer
package dseq_pkg;
    // Timing bases
    localparam int CLK_PERIOD_NS = 10;
    localparam int HS_FREQ_KHZ = 4000;
    localparam int HS_STEP_NS = 2000;
    localparam int HS_TICKS_PER_STEP = HS_STEP_NS * HS_FREQ_KHZ / 1000000;
    localparam int SLEEP_UNIT_US = 6400;
    localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_US * 1000 / CLK_PERIOD_NS;
    // Gain compensation plus fake measurements appended to each sequence
    localparam int EXTRA_CYCLES = 7;
    // Cycles per sample for each bridge code
    localparam logic [3:0] CPS_HALF = 4'h2;
    localparam logic [3:0] CPS_FULL = 4'h4;
    localparam logic [3:0] CPS_QUATTRO = 4'h8;
    localparam logic [1:0] BRIDGE_HALF = 2'h0;
    localparam logic [1:0] BRIDGE_QUATTRO = 2'h3;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG0 = 8'h04;
    localparam logic [7:0] OFS_CFG2 = 8'h08;
    localparam logic [7:0] OFS_CFG3 = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RC_BIT = 1;
    localparam int CFG0_CONV_LSB = 16;
    localparam int CFG2_SINGLE_BIT = 2;
    localparam int CFG2_CYT_LSB = 4;
    localparam int CFG2_AVR_LSB = 14;
    localparam int CFG3_BRIDGE_LSB = 0;
    localparam int CFG3_ADJ_LSB = 4;
    localparam int CFG3_STRETCH_LSB = 12;
    // Result limits, two's complement
    localparam logic [23:0] RES_MAX = 24'h7fffff;
    localparam logic [23:0] RES_MIN = 24'h800001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic enable;
        logic rc_sel;
        logic [7:0] conv_cnt;
        logic single;
        logic [9:0] cytime;
        logic [9:0] avrate;
        logic [1:0] bridge;
        logic [5:0] tdc_adjust_factor;
        logic [1:0] stretch;
    } cfg_t;

    typedef enum logic [1:0] {S_IDLE, S_DISCH, S_GAP, S_SLEEP} state_t;
endpackage

// ### verilog/discharge_sequence_timing.sv
// Discharge sequencer: cycle timing, sample grouping, oscillator gating, AXI4-Lite regs
// Operation
// - Non-stretched cycle interval is the setting times 2 us.
// - Stretched mode setting spaces successive discharges in 100 us units.
// - Non-stretched interval is timed from the high-speed clock, external resonator.
// - An internal RC oscillator can replace the resonator as high-speed source.
// - Half bridge 2, full bridge 4, quattro bridge 8 discharges per ratio.
// - One sample is the full discharge set for the chosen bridge.
// - A sequence averages the programmed sample count of samples.
// - Each sequence adds compensation and fake measurements, then yields one result.
// - Result is 24-bit two's complement, limited to 0x800001 through 0x7fffff.
// - Continuous mode measures back to back with the oscillator always on.
// - Single mode runs one sequence then sleeps, oscillator on only meanwhile.
// - Stretched mode keeps discharge count but spreads discharges out in time.
// - Stretched continuous runs the oscillator only during half-bridge pairs.
// - After a one-shot sequence the oscillator stays off during the sleep count.
// - Stretch 2 or 3 separates a half-bridge pair by 200 or 300 us.
// - Single mode sequence spacing is the interval count times 6.4 ms.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module discharge_sequence_timing #(
    parameter int SLEEP_UNIT = dseq_pkg::SLEEP_UNIT_CYC,
    parameter int TDC_W = 24
) (
    // Clock, reset, enable
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CE,
    // AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Timing sources from pins
    input wire logic HS_CLK_EXT,
    input wire logic HS_CLK_RC,
    input wire logic SLOW_CLK,
    // Discharge front end, same clock
    input wire logic TDC_VALID,
    input wire logic [TDC_W-1:0] TDC_VALUE,
    output logic DISCH_START,
    output logic OSC_EN,
    // Progress
    output logic SAMPLE_DONE,
    output logic SEQ_DONE,
    output logic SLEEPING
);
    dseq_pkg::cfg_t cfg_q;
    dseq_pkg::state_t state_q, state_d;
    logic [2:0] sy1_q, sy2_q, sy3_q, stab_q, rise;
    logic [2:0] pre_q;
    logic tick, hs_rise, stretched, long_gap, seq_end, last_in_samp, in_avg;
    logic [9:0] tick_cnt_q, target;
    logic [15:0] disch_cnt_q, avg_cycles, total;
    logic [3:0] samp_idx_q, cps;
    logic pair_q;
    logic signed [39:0] acc_q, acc_next;
    logic [23:0] result_q, sat;
    logic [7:0] unit_cnt_q;
    logic [19:0] unit_pre_q;
    logic [15:0] seq_count_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // Pin sampling: a level counts once stages two and three agree
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sy1_q <= 3'h0;
            sy2_q <= 3'h0;
            sy3_q <= 3'h0;
            stab_q <= 3'h0;
        end else if (CE) begin
            sy1_q <= {SLOW_CLK, HS_CLK_RC, HS_CLK_EXT};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            stab_q <= (~(sy2_q ^ sy3_q) & sy3_q) | ((sy2_q ^ sy3_q) & stab_q);
        end
    end
    assign rise = ~(sy2_q ^ sy3_q) & sy3_q & ~stab_q;
    assign hs_rise = cfg_q.rc_sel ? rise[1] : rise[0];
    assign stretched = (cfg_q.stretch != 2'h0);

    // High-speed prescaler: one step per eight source clocks
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pre_q <= 3'h0;
        end else if (CE && hs_rise) begin
            pre_q <= (pre_q == 3'(dseq_pkg::HS_TICKS_PER_STEP - 1)) ? 3'h0 : pre_q + 3'h1;
        end
    end
    assign tick = stretched ? rise[2]
                            : (hs_rise && pre_q == 3'(dseq_pkg::HS_TICKS_PER_STEP - 1));

    always_comb begin
        case (cfg_q.bridge)
            dseq_pkg::BRIDGE_HALF: cps = dseq_pkg::CPS_HALF;
            dseq_pkg::BRIDGE_QUATTRO: cps = dseq_pkg::CPS_QUATTRO;
            default: cps = dseq_pkg::CPS_FULL;
        endcase
    end
    // Widen before the product so quattro counts above 1023 do not wrap
    assign avg_cycles = 16'(cfg_q.avrate) * 16'(cps);
    assign total = avg_cycles + 16'(dseq_pkg::EXTRA_CYCLES);
    assign in_avg = (disch_cnt_q < avg_cycles);
    assign last_in_samp = (samp_idx_q == cps - 4'h1);
    assign seq_end = (disch_cnt_q + 16'h1 >= total);
    // Pair gap uses the stretch code itself as a count of 100 us steps
    assign long_gap = !(cfg_q.stretch[1] && pair_q);
    assign target = (stretched && !long_gap) ? {8'h0, cfg_q.stretch} : cfg_q.cytime;

    always_comb begin
        state_d = state_q;
        case (state_q)
            dseq_pkg::S_IDLE: if (cfg_q.enable) state_d = dseq_pkg::S_DISCH;
            dseq_pkg::S_DISCH: begin
                if (TDC_VALID) begin
                    if (seq_end && cfg_q.single) state_d = dseq_pkg::S_SLEEP;
                    else state_d = dseq_pkg::S_GAP;
                end
            end
            dseq_pkg::S_GAP: begin
                if (!cfg_q.enable) state_d = dseq_pkg::S_IDLE;
                else if (tick_cnt_q >= target) state_d = dseq_pkg::S_DISCH;
            end
            dseq_pkg::S_SLEEP: begin
                if (unit_cnt_q >= cfg_q.conv_cnt) begin
                    state_d = cfg_q.enable ? dseq_pkg::S_DISCH : dseq_pkg::S_IDLE;
                end
            end
            default: state_d = dseq_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) state_q <= dseq_pkg::S_IDLE;
        else if (CE) state_q <= state_d;
    end

    // Interval counter restarts at each discharge start
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            tick_cnt_q <= 10'h0;
        end else if (CE) begin
            if (state_d == dseq_pkg::S_DISCH && state_q != dseq_pkg::S_DISCH) tick_cnt_q <= 10'h0;
            else if (tick && tick_cnt_q != 10'h3ff) tick_cnt_q <= tick_cnt_q + 10'h1;
        end
    end

    // Sequence bookkeeping and result accumulation
    assign acc_next = samp_idx_q[0] ? acc_q - 40'(signed'(TDC_VALUE))
                                    : acc_q + 40'(signed'(TDC_VALUE));
    always_comb begin
        // Extra compensation discharges never enter the result
        if (acc_q > 40'(signed'(dseq_pkg::RES_MAX))) sat = dseq_pkg::RES_MAX;
        else if (acc_q < 40'(signed'(dseq_pkg::RES_MIN))) sat = dseq_pkg::RES_MIN;
        else sat = acc_q[23:0];
    end
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            disch_cnt_q <= 16'h0;
            samp_idx_q <= 4'h0;
            acc_q <= 40'sh0;
            result_q <= 24'h0;
            seq_count_q <= 16'h0;
            pair_q <= 1'b0;
        end else if (CE) begin
            if (state_q == dseq_pkg::S_IDLE) begin
                disch_cnt_q <= 16'h0;
                samp_idx_q <= 4'h0;
                acc_q <= 40'sh0;
                pair_q <= 1'b0;
            end else if (state_q == dseq_pkg::S_DISCH && TDC_VALID) begin
                pair_q <= cfg_q.stretch[1] ? !pair_q : 1'b0;
                if (seq_end) begin
                    disch_cnt_q <= 16'h0;
                    samp_idx_q <= 4'h0;
                    acc_q <= 40'sh0;
                    result_q <= sat;
                    seq_count_q <= seq_count_q + 16'h1;
                end else begin
                    disch_cnt_q <= disch_cnt_q + 16'h1;
                    if (in_avg) begin
                        samp_idx_q <= last_in_samp ? 4'h0 : samp_idx_q + 4'h1;
                        acc_q <= acc_next;
                    end
                end
            end
        end
    end

    // Sleep timer in 6.4 ms units
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            unit_pre_q <= 20'h0;
            unit_cnt_q <= 8'h0;
        end else if (CE) begin
            if (state_q != dseq_pkg::S_SLEEP) begin
                unit_pre_q <= 20'h0;
                unit_cnt_q <= 8'h0;
            end else if (unit_pre_q == 20'(SLEEP_UNIT - 1)) begin
                unit_pre_q <= 20'h0;
                unit_cnt_q <= unit_cnt_q + 8'h1;
            end else begin
                unit_pre_q <= unit_pre_q + 20'h1;
            end
        end
    end

    // Registered outputs toward the front end
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            DISCH_START <= 1'b0;
            OSC_EN <= 1'b0;
            SAMPLE_DONE <= 1'b0;
            SEQ_DONE <= 1'b0;
            SLEEPING <= 1'b0;
        end else if (CE) begin
            DISCH_START <= (state_d == dseq_pkg::S_DISCH && state_q != dseq_pkg::S_DISCH);
            SAMPLE_DONE <= (state_q == dseq_pkg::S_DISCH && TDC_VALID && in_avg
                            && last_in_samp);
            SEQ_DONE <= (state_q == dseq_pkg::S_DISCH && TDC_VALID && seq_end);
            SLEEPING <= (state_d == dseq_pkg::S_SLEEP);
            if (!stretched) begin
                OSC_EN <= (state_d == dseq_pkg::S_DISCH || state_d == dseq_pkg::S_GAP);
            end else begin
                // Oscillator only around each pair; startup delay is the user's margin
                OSC_EN <= (state_d == dseq_pkg::S_DISCH)
                          || (state_d == dseq_pkg::S_GAP && cfg_q.stretch[1] && !pair_q
                              && state_q == dseq_pkg::S_DISCH && TDC_VALID)
                          || (state_d == dseq_pkg::S_GAP && state_q == dseq_pkg::S_GAP
                              && !long_gap);
            end
        end
    end

    // AXI4-Lite write: address and data taken in either order
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= dseq_pkg::RESP_OKAY;
            cfg_q <= '0;
        end else if (CE) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) S_AXI_BVALID <= 1'b0;
            if (aw_hold_q && w_hold_q && !S_AXI_BVALID) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= dseq_pkg::RESP_OKAY;
                // A write lands only when every byte holding the register's fields is strobed
                case (aw_addr_q)
                    dseq_pkg::OFS_CTRL: if (w_strb_q[0]) begin
                        cfg_q.enable <= w_data_q[dseq_pkg::CTRL_EN_BIT];
                        cfg_q.rc_sel <= w_data_q[dseq_pkg::CTRL_RC_BIT];
                    end
                    dseq_pkg::OFS_CFG0: if (w_strb_q[2])
                        cfg_q.conv_cnt <= w_data_q[dseq_pkg::CFG0_CONV_LSB +: 8];
                    dseq_pkg::OFS_CFG2: if (&w_strb_q[2:0]) begin
                        cfg_q.single <= w_data_q[dseq_pkg::CFG2_SINGLE_BIT];
                        cfg_q.cytime <= w_data_q[dseq_pkg::CFG2_CYT_LSB +: 10];
                        cfg_q.avrate <= w_data_q[dseq_pkg::CFG2_AVR_LSB +: 10];
                    end
                    dseq_pkg::OFS_CFG3: if (&w_strb_q[1:0]) begin
                        cfg_q.bridge <= w_data_q[dseq_pkg::CFG3_BRIDGE_LSB +: 2];
                        cfg_q.tdc_adjust_factor <= w_data_q[dseq_pkg::CFG3_ADJ_LSB +: 6];
                        cfg_q.stretch <= w_data_q[dseq_pkg::CFG3_STRETCH_LSB +: 2];
                    end
                    default: S_AXI_BRESP <= dseq_pkg::RESP_SLVERR;
                endcase
            end
        end
    end
    assign S_AXI_AWREADY = !aw_hold_q;
    assign S_AXI_WREADY = !w_hold_q;

    // AXI4-Lite read: one cycle after address acceptance
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= dseq_pkg::RESP_OKAY;
        end else if (CE) begin
            if (S_AXI_RVALID && S_AXI_RREADY) S_AXI_RVALID <= 1'b0;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= dseq_pkg::RESP_OKAY;
                case (S_AXI_ARADDR)
                    dseq_pkg::OFS_CTRL: S_AXI_RDATA <= {30'h0, cfg_q.rc_sel, cfg_q.enable};
                    dseq_pkg::OFS_CFG0: S_AXI_RDATA <= {8'h0, cfg_q.conv_cnt, 16'h0};
                    dseq_pkg::OFS_CFG2: S_AXI_RDATA <= {8'h0, cfg_q.avrate, cfg_q.cytime,
                                                        1'b0, cfg_q.single, 2'h0};
                    dseq_pkg::OFS_CFG3: S_AXI_RDATA <= {18'h0, cfg_q.stretch, 2'h0,
                                                        cfg_q.tdc_adjust_factor, 2'h0,
                                                        cfg_q.bridge};
                    dseq_pkg::OFS_STATUS: S_AXI_RDATA <= {seq_count_q, 13'h0, pair_q, state_q};
                    dseq_pkg::OFS_RESULT: S_AXI_RDATA <= {{8{result_q[23]}}, result_q};
                    default: begin
                        S_AXI_RDATA <= 32'h0;
                        S_AXI_RRESP <= dseq_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    hs_prescale_a: assert property (CE && !stretched && tick |-> hs_rise && pre_q == 3'h7)
        else $error("interval step without eighth high-speed edge");
    gap_length_a: assert property (CE && state_q == dseq_pkg::S_GAP
                                   && state_d == dseq_pkg::S_DISCH |-> tick_cnt_q >= target)
        else $error("discharge started before interval expired");
    result_range_a: assert property (result_q != 24'h800000)
        else $error("result outside signed limit");
    cont_osc_a: assert property (CE && !stretched && state_q == dseq_pkg::S_GAP
                                 && cfg_q.enable |=> OSC_EN)
        else $error("oscillator off in continuous run");
    sleep_osc_a: assert property (state_q == dseq_pkg::S_SLEEP
                                  && $past(state_q) == dseq_pkg::S_SLEEP |-> !OSC_EN)
        else $error("oscillator on during sleep count");
    stretch_osc_a: assert property (CE && stretched && state_q == dseq_pkg::S_GAP && long_gap
                                    && state_d == dseq_pkg::S_GAP |=> !OSC_EN)
        else $error("oscillator on in stretched long gap");
    seq_end_a: assert property (CE && state_q == dseq_pkg::S_DISCH && TDC_VALID && seq_end
                                |=> SEQ_DONE && disch_cnt_q == 16'h0)
        else $error("sequence end not flagged");
    sample_size_a: assert property (SAMPLE_DONE |-> $past(samp_idx_q) == cps - 4'h1)
        else $error("sample closed at wrong discharge count");
    single_sleep_a: assert property (CE && SEQ_DONE && cfg_q.single
                                     |-> state_q == dseq_pkg::S_SLEEP)
        else $error("single conversion did not sleep");

    seq_cov_c: cover property (SEQ_DONE);
    sleep_cov_c: cover property (SLEEPING ##1 !SLEEPING);
    stretch_cov_c: cover property (stretched && DISCH_START);
endmodule

// ### dv/discharge_sequence_timing_test.sv
// Self-checking bench for the discharge sequencer
`timescale 1ns/1ps
module discharge_sequence_timing_test;
    localparam logic [1:0] OK = dseq_pkg::RESP_OKAY;
    localparam logic [1:0] ER = dseq_pkg::RESP_SLVERR;
    localparam logic [7:0] C2 = dseq_pkg::OFS_CFG2;
    logic clock = 0, rst_n = 0, aw_valid = 0, w_valid = 0, ar_valid = 0;
    logic [7:0] aw_addr = 0, ar_addr = 0;
    logic [31:0] w_data = 0, r_data;
    logic [3:0] w_strb = 0;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, ds_start, osc_en;
    logic sample_done, seq_done, sleeping, sl_q = 0;
    logic [1:0] b_resp, r_resp;
    logic hs_ext = 0, hs_rc = 0, slow = 0, tdc_valid = 0, rc_on = 0;
    logic [23:0] tdc_value = 0;
    logic signed [23:0] va, vb, vc;
    int num_errors = 0, checks = 0, hs_n = 0, sl_c = 0, since_ds = 0, rsp = 0;
    int k = 0, kds = 0, ds_n = 0, samp_n = 0, seq_cnt = 0, sl_n = 0, sleeps = 0;
    int exp_n, avr, cyt, str, single, conv, have = 0, on = 0, unit, tgt;

    always #5 clock = ~clock;

    discharge_sequence_timing #(.SLEEP_UNIT(20), .TDC_W(24)) dut (
        .CLOCK(clock), .RST_N(rst_n), .CE(1'b1),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
        .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
        .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid),
        .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
        .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
        .S_AXI_RVALID(r_valid), .S_AXI_RREADY(1'b1), .HS_CLK_EXT(hs_ext), .HS_CLK_RC(hs_rc),
        .SLOW_CLK(slow), .TDC_VALID(tdc_valid), .TDC_VALUE(tdc_value),
        .DISCH_START(ds_start), .OSC_EN(osc_en), .SAMPLE_DONE(sample_done),
        .SEQ_DONE(seq_done), .SLEEPING(sleeping));

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic results();
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic give_up();
        cmp(32'h0, 32'h1);
        results();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        bit ad, wd, dn;
        int n;
        ad = 0;
        wd = 0;
        dn = 0;
        aw_addr <= a;
        aw_valid <= 1'b1;
        w_data <= d;
        w_strb <= s;
        w_valid <= 1'b1;
        for (n = 0; n < 100 && !dn; n++) begin
            @(posedge clock);
            dn = b_valid;
            if (!ad && aw_ready) begin
                ad = 1;
                aw_valid <= 1'b0;
            end
            if (!wd && w_ready) begin
                wd = 1;
                w_valid <= 1'b0;
            end
        end
        if (!dn) give_up();
        cmp(32'(b_resp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        bit dn;
        dn = 0;
        ar_addr <= a;
        ar_valid <= 1'b1;
        // Previous answer may still show valid in this time step
        for (n = 0; n < 100 && !dn; n++) begin
            @(posedge clock);
            dn = r_valid;
            if (ar_ready) ar_valid <= 1'b0;
        end
        if (!dn) give_up();
        d = r_data;
        cmp(32'(r_resp), 32'(er));
    endtask

    function automatic logic [23:0] exp_res(input int n, input logic signed [23:0] a,
                                            input logic signed [23:0] b);
        longint s;
        s = longint'(n / 2) * (longint'(a) - longint'(b));
        if (s > 64'sh7fffff) s = 64'sh7fffff;
        if (s < -64'sh7fffff) s = -64'sh7fffff;
        return s[23:0];
    endfunction

    // Timing sources: resonator or RC at 4 MHz, slow clock at 100 kHz
    always @(posedge clock) begin
        hs_n <= (hs_n == 24) ? 0 : hs_n + 1;
        sl_c <= (sl_c == 999) ? 0 : sl_c + 1;
        hs_ext <= !rc_on && hs_n < 12;
        hs_rc <= rc_on && hs_n > 6 && hs_n < 19;
        slow <= sl_c < 500;
    end

    // Front end answers 5 cycles after each start; also watches spacing and gating
    always @(posedge clock) begin
        tdc_valid <= 1'b0;
        since_ds++;
        if (rsp > 0) begin
            rsp--;
            if (rsp == 0) begin
                tdc_valid <= 1'b1;
                tdc_value <= (k >= exp_n) ? vc : (k[0] ? vb : va);
                k++;
            end
        end
        if (sample_done) samp_n++;
        if (seq_done) begin
            cmp(ds_n, exp_n + 7);
            cmp(samp_n, avr);
            ds_n = 0;
            samp_n = 0;
            k = 0;
            seq_cnt++;
            if (str != 0 || single != 0) have = 0;
        end
        if (ds_start) begin
            unit = (str != 0) ? 1000 : 200;
            tgt = (str != 0 && !kds[0]) ? str : cyt;
            if (have != 0)
                cmp((since_ds >= (tgt - 1) * unit && since_ds <= tgt * unit + 40) ?
                    tgt * unit : since_ds, tgt * unit);
            have = 1;
            since_ds = 0;
            kds = k;
            rsp = 5;
            ds_n++;
        end
        if (on != 0 && have != 0 && str == 0 && since_ds == 100) cmp(32'(osc_en), 32'h1);
        if (on != 0 && have != 0 && str != 0 && since_ds == 500)
            cmp(32'(osc_en), 32'(!kds[0]));
        if (sleeping) begin
            sl_n++;
            cmp(32'(osc_en), 32'h0);
        end
        if (sl_q && !sleeping) begin
            cmp((sl_n >= conv * 20 && sl_n <= conv * 20 + 1) ? conv * 20 : sl_n, conv * 20);
            sl_n = 0;
            sleeps++;
        end
        sl_q = sleeping;
    end

    task automatic run(input logic [1:0] br, input int av, cy, st, sg, cv, rc);
        logic [31:0] d;
        int n, s0;
        exp_n = av * ((br == 2'h0) ? 2 : (br == 2'h3) ? 8 : 4);
        avr = av;
        cyt = cy;
        str = st;
        single = sg;
        conv = cv;
        rc_on <= rc[0];
        wr(dseq_pkg::OFS_CFG0, 32'(cv << 16), 4'hf, OK);
        wr(C2, 32'((sg << 2) | (cy << 4) | (av << 14)), 4'hf, OK);
        wr(dseq_pkg::OFS_CFG3, 32'(br | ((2 * av) << 4) | (st << 12)), 4'hf, OK);
        k = 0;
        ds_n = 0;
        samp_n = 0;
        on = 1;
        s0 = seq_cnt;
        wr(dseq_pkg::OFS_CTRL, 32'(1 | (rc << 1)), 4'hf, OK);
        for (n = 0; n < 60000 && seq_cnt == s0; n++) @(posedge clock);
        if (n == 60000) give_up();
        rd(dseq_pkg::OFS_RESULT, OK, d);
        cmp(d, 32'(signed'(exp_res(exp_n, va, vb))));
        if (sg != 0) begin
            s0 = sleeps;
            for (n = 0; n < 3000 && ds_n == 0; n++) @(posedge clock);
            cmp(sleeps, s0 + 1);
        end
        on = 0;
        have = 0;
        wr(dseq_pkg::OFS_CTRL, 32'h0, 4'hf, OK);
        for (n = 0; n < 5000; n++) begin
            rd(dseq_pkg::OFS_STATUS, OK, d);
            if (d[1:0] == 2'h0) break;
        end
    endtask

    initial begin
        logic [31:0] d, r;
        void'($urandom(32'hde3e));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(C2, OK, d);
        cmp(d, 32'h0);
        r = $urandom() & 32'h00fffff4;
        wr(C2, r, 4'hf, OK);
        rd(C2, OK, d);
        cmp(d, r);
        // Partial strobe must leave the word alone
        wr(C2, 32'h0, 4'h1, OK);
        rd(C2, OK, d);
        cmp(d, r);
        wr(8'h18, r, 4'hf, ER);
        rd(8'h18, ER, d);
        cmp(d, 32'h0);
        for (int i = 0; i < 6; i++) begin
            va = 24'($signed(20'($urandom())));
            vb = 24'($signed(20'($urandom())));
            vc = 24'($urandom());
            if (i == 4) begin
                va = dseq_pkg::RES_MAX;
                vb = dseq_pkg::RES_MIN;
            end
            if (i == 5) begin
                va = dseq_pkg::RES_MIN;
                vb = dseq_pkg::RES_MAX;
            end
            run(2'(i), 2 * $urandom_range(1, 2), $urandom_range(2, 4), 0, 0, 0, i % 2);
        end
        run(dseq_pkg::BRIDGE_HALF, 2, 2, 0, 1, 3, 0);
        run(dseq_pkg::BRIDGE_HALF, 2, 3, 2, 0, 0, 0);
        run(dseq_pkg::BRIDGE_HALF, 2, 3, 3, 0, 0, 0);
        results();
    end
endmodule
